// [shared/vrc_pkg.sv]
// register map, field layout and reset values of the reference control bank
package vrc_pkg;

    // register indices; byte address is four times the index
    localparam logic [2:0] VRC_IDX_CONTROL = 3'h1;
    localparam logic [2:0] VRC_IDX_IRQ_STATUS = 3'h2;
    localparam logic [2:0] VRC_IDX_IRQ_MASK = 3'h3;
    localparam logic [4:0] VRC_ADDR_CONTROL = 5'h04;
    localparam logic [4:0] VRC_ADDR_IRQ_STATUS = 5'h08;
    localparam logic [4:0] VRC_ADDR_IRQ_MASK = 5'h0c;

    // reference_status_control field positions
    localparam int VRC_BIT_ENABLE = 7;
    localparam int VRC_BIT_REGULATOR = 6;
    localparam int VRC_BIT_CURV_COMP = 5;
    localparam int VRC_BIT_RSVD_HI = 4;
    localparam int VRC_BIT_RSVD_LO = 3;
    localparam int VRC_BIT_STABLE = 2;
    localparam int VRC_MODE_MSB = 1;
    localparam int VRC_MODE_LSB = 0;

    // interrupt status and mask bit positions
    localparam int VRC_EVT_STABLE_RISE = 0;
    localparam int VRC_EVT_STABLE_LOSS = 1;
    localparam int VRC_EVT_WIDTH = 2;

    // values after reset
    localparam logic [7:0] VRC_CONTROL_RESET = 8'h00;
    localparam logic [1:0] VRC_EVT_RESET = 2'h0;
    localparam logic [31:0] VRC_READ_RESET = 32'h0000_0000;

    // synchroniser depth for the analog ready level
    localparam int VRC_SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        VRC_MODE_BANDGAP_ONLY = 2'b00,
        VRC_MODE_HIGH_POWER = 2'b01,
        VRC_MODE_LOW_POWER = 2'b10,
        VRC_MODE_RESERVED = 2'b11
    } vrc_mode_e;

endpackage

// [hdl/vrc_top.sv]
// reference control register bank with avalon-mm slave and interrupt
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
// Function
// - bit 7 enables the bandgap reference; 0 disables it, while bits 6, 5 and 1:0 still drive their outputs.
// - bus clock gating never disables the reference; only clearing bit 7 or rst_n does.
// - bit 6 drives the 1.75 V regulator enable, 1 on, 0 off.
// - bit 5 drives curvature compensation enable, 1 on, 0 off.
// - bits 4 and 3 read zero and ignore writes.
// - bit 2 reads 1 once bandgap is stable, 0 when disabled or unstable.
// - bits 1:0 pick buffer mode: bandgap only, high, low power, reserved.
// - the control register is 8 bits, read/write, reset to zero.
// - changing buffer mode while enabled and stable keeps stable flag.
module vrc_top
    import vrc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog reference controls
    output logic reference_enable,
    output logic regulator_enable,
    output logic curvature_comp_enable,
    output logic [1:0] buffer_mode_select,
    // analog stable indication, asynchronous
    input wire logic analog_ready,
    // interrupt
    output logic irq
);

    logic [VRC_SYNC_STAGES-1:0] ready_sync;
    logic ready_filt;
    logic reference_stable;
    logic stable_prev;
    logic [VRC_EVT_WIDTH-1:0] irq_status;
    logic [VRC_EVT_WIDTH-1:0] irq_mask;
    logic [VRC_EVT_WIDTH-1:0] next_irq_status;
    logic [VRC_EVT_WIDTH-1:0] next_irq_mask;
    logic [VRC_EVT_WIDTH-1:0] evt_set;
    logic req;
    logic accept;
    logic wr_accept;
    logic lane0;
    logic [7:0] control_view;
    logic [31:0] next_readdata;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------

    // a request is held by the master until waitrequest is seen low
    assign req = avs_read | avs_write;
    assign accept = req & ~avs_waitrequest;
    assign wr_accept = avs_write & ~avs_waitrequest;
    assign lane0 = avs_byteenable[0];

    // one wait cycle gives time to register read data before acceptance
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else if (accept) begin
            avs_waitrequest <= 1'b1;
        end else if (req) begin
            avs_waitrequest <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------

    always_comb begin
        control_view = VRC_CONTROL_RESET;
        control_view[VRC_BIT_ENABLE] = reference_enable;
        control_view[VRC_BIT_REGULATOR] = regulator_enable;
        control_view[VRC_BIT_CURV_COMP] = curvature_comp_enable;
        // reserved bits are forced to zero explicitly
        control_view[VRC_BIT_RSVD_HI] = 1'b0;
        control_view[VRC_BIT_RSVD_LO] = 1'b0;
        control_view[VRC_BIT_STABLE] = reference_stable;
        control_view[VRC_MODE_MSB:VRC_MODE_LSB] = buffer_mode_select;
    end

    always_comb begin
        next_readdata = VRC_READ_RESET;
        case (avs_address)
            VRC_ADDR_CONTROL: begin
                next_readdata[7:0] = control_view;
            end
            VRC_ADDR_IRQ_STATUS: begin
                next_readdata[VRC_EVT_WIDTH-1:0] = irq_status;
            end
            VRC_ADDR_IRQ_MASK: begin
                next_readdata[VRC_EVT_WIDTH-1:0] = irq_mask;
            end
            default: begin
                // unmapped addresses read as zero
                next_readdata = VRC_READ_RESET;
            end
        endcase
    end

    // captured in the wait cycle so data stands at the accepting edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= VRC_READ_RESET;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------

    // the control bits sit in this always-on domain, so stopping the
    // peripheral clock gate upstream never clears them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reference_enable <= VRC_CONTROL_RESET[VRC_BIT_ENABLE];
            regulator_enable <= VRC_CONTROL_RESET[VRC_BIT_REGULATOR];
            curvature_comp_enable <= VRC_CONTROL_RESET[VRC_BIT_CURV_COMP];
            buffer_mode_select <=
                VRC_CONTROL_RESET[VRC_MODE_MSB:VRC_MODE_LSB];
        end else if (wr_accept && lane0
                     && avs_address == VRC_ADDR_CONTROL) begin
            reference_enable <= avs_writedata[VRC_BIT_ENABLE];
            regulator_enable <= avs_writedata[VRC_BIT_REGULATOR];
            curvature_comp_enable <= avs_writedata[VRC_BIT_CURV_COMP];
            // reserved code 11 is stored as written; software avoids it
            buffer_mode_select <=
                avs_writedata[VRC_MODE_MSB:VRC_MODE_LSB];
        end
    end

    // ------------------------------------------------------------
    // stable flag
    // ------------------------------------------------------------

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_sync <= '0;
        end else begin
            ready_sync <= {ready_sync[VRC_SYNC_STAGES-2:0], analog_ready};
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_filt <= 1'b0;
        end else if (ready_sync[2] == ready_sync[1]) begin
            ready_filt <= ready_sync[2];
        end
    end

    // mode changes do not touch this flag; only enable and ready do
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reference_stable <= 1'b0;
        end else begin
            reference_stable <= reference_enable & ready_filt;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_prev <= 1'b0;
        end else begin
            stable_prev <= reference_stable;
        end
    end

    assign evt_set[VRC_EVT_STABLE_RISE] = reference_stable & ~stable_prev;
    assign evt_set[VRC_EVT_STABLE_LOSS] = ~reference_stable & stable_prev;

    // a new event wins over a write-one-to-clear in the same cycle
    always_comb begin
        next_irq_status = irq_status;
        if (wr_accept && lane0 && avs_address == VRC_ADDR_IRQ_STATUS) begin
            next_irq_status = irq_status
                              & ~avs_writedata[VRC_EVT_WIDTH-1:0];
        end
        next_irq_status = next_irq_status | evt_set;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= VRC_EVT_RESET;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_accept && lane0 && avs_address == VRC_ADDR_IRQ_MASK) begin
            next_irq_mask = avs_writedata[VRC_EVT_WIDTH-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= VRC_EVT_RESET;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // next mask as well, so irq never lags a mask write by a cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_irq_status & next_irq_mask);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------

    logic ctl_write;
    assign ctl_write = wr_accept & lane0 & (avs_address == VRC_ADDR_CONTROL);

    sequence s_ctl_write;
        ctl_write;
    endsequence

    sequence s_no_ctl_write;
        !ctl_write;
    endsequence

    sequence s_ready_held;
        (analog_ready && reference_enable)[*6];
    endsequence

    AST_ENABLE_FOLLOWS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_ctl_write |=> reference_enable
            == $past(avs_writedata[VRC_BIT_ENABLE]))
        else $error("enable output does not follow bit 7 write");

    AST_HOLD_OUTPUTS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_no_ctl_write |=> $stable(reference_enable)
            && $stable(regulator_enable)
            && $stable(curvature_comp_enable)
            && $stable(buffer_mode_select))
        else $error("control output changed without a write");

    AST_REGULATOR_FOLLOWS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_ctl_write |=> regulator_enable
            == $past(avs_writedata[VRC_BIT_REGULATOR]))
        else $error("regulator enable does not follow bit 6");

    AST_COMP_FOLLOWS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_ctl_write |=> curvature_comp_enable
            == $past(avs_writedata[VRC_BIT_CURV_COMP]))
        else $error("curvature enable does not follow bit 5");

    AST_RESERVED_ZERO: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (avs_read && !avs_waitrequest
            && avs_address == VRC_ADDR_CONTROL)
        |-> avs_readdata[VRC_BIT_RSVD_HI:VRC_BIT_RSVD_LO] == 2'b00)
        else $error("reserved bits read non-zero");

    AST_STABLE_OFF: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        !reference_enable |=> !reference_stable)
        else $error("stable flag set while disabled");

    AST_MODE_FOLLOWS: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_ctl_write |=> buffer_mode_select
            == $past(avs_writedata[1:0]))
        else $error("buffer mode does not follow bits 1:0");

    AST_MODE_KEEPS_STABLE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (s_ctl_write and reference_stable && ready_filt
            && avs_writedata[VRC_BIT_ENABLE])
        |=> ##1 reference_stable)
        else $error("stable flag lost on mode change");

    AST_SYNC_STABLE: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        s_ready_held |=> reference_stable)
        else $error("stable flag missing after ready held");

    AST_READ_CONTROL: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (avs_read && !avs_waitrequest
            && avs_address == VRC_ADDR_CONTROL)
        |-> avs_readdata[VRC_BIT_ENABLE] == reference_enable
            && avs_readdata[VRC_MODE_MSB:VRC_MODE_LSB]
                == buffer_mode_select)
        else $error("control read does not show register contents");

    AST_WRITE_TIMING: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        ($rose(avs_write) && avs_waitrequest)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("write not accepted after one wait cycle");

    AST_IRQ_LEVEL: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        irq == |(irq_status & irq_mask))
        else $error("interrupt output disagrees with status and mask");

endmodule

// [verif/vrc_bandgap_model.sv]
// behavioural bandgap that reports ready some cycles after enable
`timescale 1ns/10ps
module vrc_bandgap_model #(
    parameter int STARTUP = 20
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control from the bank
    input wire logic reference_enable,
    // stable indication back to the bank
    output logic analog_ready
);
    int cnt;
    // negedge keeps ready unaligned with the bank's sampling edge
    always_ff @(negedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
        end else if (!reference_enable) begin
            cnt <= 0;
        end else if (cnt < STARTUP) begin
            cnt <= cnt + 1;
        end
    end
    // drops at once when disabled, as the analog side would
    assign analog_ready = reference_enable && (cnt >= STARTUP);
endmodule

// [verif/tb_vrc_top.sv]
// self-checking bench for the reference control bank
`timescale 1ns/10ps
module tb_vrc_top
    import vrc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, reference_enable, regulator_enable;
    logic curvature_comp_enable, analog_ready, irq;
    logic [1:0] buffer_mode_select;
    int num_errors = 0;
    int n_tests = 0;

    vrc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .reference_enable(reference_enable),
        .regulator_enable(regulator_enable),
        .curvature_comp_enable(curvature_comp_enable),
        .buffer_mode_select(buffer_mode_select),
        .analog_ready(analog_ready), .irq(irq));
    vrc_bandgap_model #(.STARTUP(20)) i_gap (.ref_clk(ref_clk),
        .rst_n(rst_n), .reference_enable(reference_enable),
        .analog_ready(analog_ready));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // waitrequest and readdata are registered, so the value seen just
    // after a rising edge is the one that edge sampled
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 20) chk(32'h1, 32'h0, "bus answer missing");
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        // one idle edge so the next request never re-raises in this step
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hf, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 8'h00, 4'hf, q);
    endtask

    task automatic irq_chk(input logic exp, input string what);
        repeat (2) @(negedge ref_clk);
        chk(irq, exp, what);
        @(posedge ref_clk);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        rd(VRC_ADDR_CONTROL, q);
        chk(q, {24'h0, VRC_CONTROL_RESET}, "control reset");
        chk({reference_enable, regulator_enable, curvature_comp_enable,
             buffer_mode_select, irq}, 32'h0, "outputs reset");
        rd(VRC_ADDR_IRQ_MASK, q);
        chk(q, VRC_READ_RESET, "mask reset");
        $display("test reset done");
    endtask

    task automatic t_fields();
        logic [31:0] q;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            wr(VRC_ADDR_CONTROL, {6'h0f, m});
            rd(VRC_ADDR_CONTROL, q);
            chk(q, {24'h0, 6'h08, m}, "mode readback");
            chk(buffer_mode_select, m, "mode output");
            chk(curvature_comp_enable, 1'b1, "comp on");
            chk(reference_enable, 1'b0, "still off");
        end
        wr(VRC_ADDR_CONTROL, 8'h00);
        chk(curvature_comp_enable, 1'b0, "comp off");
        $display("test fields done");
    endtask

    task automatic t_stable();
        logic [31:0] q;
        int n;
        wr(VRC_ADDR_CONTROL, 8'ha0);
        chk(reference_enable, 1'b1, "enable");
        repeat (4) @(posedge ref_clk);
        wr(VRC_ADDR_CONTROL, 8'he0);
        chk(regulator_enable, 1'b1, "regulator on");
        n = 0;
        do begin
            rd(VRC_ADDR_CONTROL, q);
            n++;
        end while (q[2] !== 1'b1 && n < 40);
        chk(q, 32'he4, "stable set");
        rd(VRC_ADDR_IRQ_STATUS, q);
        chk(q, 32'h1, "rise event");
        chk(irq, 1'b0, "masked");
        for (int i = 1; i < 3; i++) begin
            wr(VRC_ADDR_CONTROL, 8'he0 | i[7:0]);
            rd(VRC_ADDR_CONTROL, q);
            chk(q, 32'he4 | i, "mode kept stable");
        end
        repeat (30) @(posedge ref_clk);
        chk(reference_enable, 1'b1, "holds idle");
        bus(1'b1, VRC_ADDR_CONTROL, 8'h00, 4'he, q);
        chk(reference_enable, 1'b1, "no byte lane");
        wr(5'h10, 8'hff);
        rd(5'h10, q);
        chk(q, 32'h0, "unmapped");
        rd(VRC_ADDR_CONTROL, q);
        chk(q, 32'he6, "unmapped no effect");
        wr(VRC_ADDR_IRQ_MASK, 8'h01);
        irq_chk(1'b1, "irq raised");
        wr(VRC_ADDR_IRQ_STATUS, 8'h01);
        irq_chk(1'b0, "irq cleared");
        $display("test stable done");
    endtask

    task automatic t_disable();
        logic [31:0] q;
        wr(VRC_ADDR_CONTROL, 8'h00);
        chk(reference_enable, 1'b0, "disable");
        chk({regulator_enable, curvature_comp_enable, buffer_mode_select},
            32'h0, "controls off");
        rd(VRC_ADDR_CONTROL, q);
        chk(q, 32'h0, "stable cleared");
        rd(VRC_ADDR_IRQ_STATUS, q);
        chk(q, 32'h2, "loss event");
        wr(VRC_ADDR_IRQ_MASK, 8'h02);
        irq_chk(1'b1, "loss irq");
        wr(VRC_ADDR_IRQ_STATUS, 8'h02);
        irq_chk(1'b0, "loss cleared");
        $display("test disable done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        t_reset();
        t_fields();
        t_stable();
        t_disable();
        print_verdict();
    end

    // the full run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
endmodule
